// >>> inc/motor_startup_pkg.sv
// constants and types for the motor start-up configuration register bank
`default_nettype none
package motor_startup_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] FIRST_OFFSET = 8'h84;
  localparam logic [7:0] SECOND_OFFSET = 8'h86;
  localparam logic [7:0] STATUS_OFFSET = 8'h8C;
  localparam logic [31:0] FIRST_RESET = 32'h00000000;
  localparam logic [31:0] SECOND_RESET = 32'h00000000;
  localparam logic [4:0] THRESHOLD_LAST_CODE = 5'h11;
  localparam logic [4:0] HANDOFF_LAST_CODE = 5'h18;
  localparam logic [3:0] ACCEL2_GAP_CODE = 4'hA;

  typedef enum logic [1:0] {
    METHOD_ALIGN = 2'h0,
    METHOD_DOUBLE_ALIGN = 2'h1,
    METHOD_POSITION_DETECT = 2'h2,
    METHOD_SLOW_FIRST_CYCLE = 2'h3
  } start_method_select_type;

  typedef struct packed {
    start_method_select_type startMethod;
    logic [4:0] detectThreshold;
    logic releaseTristate;
    logic [1:0] advanceAngle;
    logic [2:0] repeatCount;
    logic limitFromGeneral;
    logic torqueRampEnable;
    logic activeBrakeEnable;
    logic reverseUsesOwn;
  } startup_first_type;

  typedef struct packed {
    logic [3:0] openLoopLimit;
    logic [3:0] accelFirstOrder;
    logic [3:0] accelSecondOrder;
    logic autoHandoff;
    logic [4:0] handoffThreshold;
  } startup_second_type;
endpackage : motor_startup_pkg
`default_nettype wire

// >>> logic/motor_startup_config_regs.sv
// avalon register bank for the motor start-up settings
`timescale 1ns/1ps
`default_nettype none
module motor_startup_config_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  output motor_startup_pkg::startup_first_type firstCfg,
  output motor_startup_pkg::startup_second_type secondCfg,
  output logic [6:0] advanceDegrees,
  output logic reservedCode
);
  // ****************************************
  // bus handshake
  // ****************************************
  // one wait cycle: request seen with waitrequest high, answered next edge
  logic [31:0] firstReg;
  logic [31:0] secondReg;
  logic busy;
  logic accept;
  logic start;
  logic [31:0] mask;
  logic hitFirst;
  logic hitSecond;
  logic hitStatus;
  logic badCode;

  assign accept = busy && (read || write);
  // a fresh request: not the tail of one already answered
  assign start = (read || write) && !busy && waitrequest;
  assign hitFirst = address == motor_startup_pkg::FIRST_OFFSET;
  assign hitSecond = address == motor_startup_pkg::SECOND_OFFSET;
  assign hitStatus = address == motor_startup_pkg::STATUS_OFFSET;
  assign mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      busy <= start;
      waitrequest <= !start;
    end
  end

  // ****************************************
  // storage
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      firstReg <= motor_startup_pkg::FIRST_RESET;
    end else if (accept && write && hitFirst) begin
      firstReg <= (firstReg & ~mask) | (writedata & mask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      secondReg <= motor_startup_pkg::SECOND_RESET;
    end else if (accept && write && hitSecond) begin
      secondReg <= (secondReg & ~mask) | (writedata & mask);
    end
  end

  // undefined encodings are stored but flagged for software
  assign badCode = (firstReg[13:9] > motor_startup_pkg::THRESHOLD_LAST_CODE)
    || (secondReg[22:19] == motor_startup_pkg::ACCEL2_GAP_CODE)
    || (secondReg[17:13] > motor_startup_pkg::HANDOFF_LAST_CODE);

  // loaded as waitrequest falls, so data already stand when the master samples it low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
      response <= 2'h0;
    end else if (start && read) begin
      readdata <= hitFirst ? firstReg : hitSecond ? secondReg
        : hitStatus ? {31'h00000000, badCode} : 32'h00000000;
      response <= (hitFirst || hitSecond || hitStatus) ? 2'h0 : 2'h2;
    end else if (start) begin
      response <= (hitFirst || hitSecond) ? 2'h0 : 2'h2;
    end
  end

  // ****************************************
  // decoded settings
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      firstCfg <= '0;
    end else begin
      firstCfg.startMethod <= motor_startup_pkg::start_method_select_type'(firstReg[30:29]);
      firstCfg.detectThreshold <= firstReg[13:9];
      firstCfg.releaseTristate <= firstReg[8];
      firstCfg.advanceAngle <= firstReg[7:6];
      firstCfg.repeatCount <= {1'b0, firstReg[5:4]} + 3'h1;
      firstCfg.limitFromGeneral <= firstReg[3];
      firstCfg.torqueRampEnable <= firstReg[2];
      firstCfg.activeBrakeEnable <= firstReg[1];
      firstCfg.reverseUsesOwn <= firstReg[0];
    end
  end

  // product kept at seven bits so that 90 does not wrap
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      advanceDegrees <= 7'h00;
    end else begin
      advanceDegrees <= {5'h00, firstReg[7:6]} * 7'h1E;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      secondCfg <= '0;
    end else begin
      secondCfg.openLoopLimit <= secondReg[30:27];
      secondCfg.accelFirstOrder <= secondReg[26:23];
      secondCfg.accelSecondOrder <= secondReg[22:19];
      secondCfg.autoHandoff <= secondReg[18];
      secondCfg.handoffThreshold <= secondReg[17:13];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reservedCode <= 1'b0;
    end else begin
      reservedCode <= badCode;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_reset_zero;
    @(posedge core_clk) !rst_n |=> firstReg == 32'h00000000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("first reg not zero after reset");
  property p_one_wait;
    @(posedge core_clk) disable iff (!rst_n)
      (read || write) && waitrequest && !busy |=> !waitrequest ##1 waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("handshake not one wait cycle");
  property p_write_first;
    @(posedge core_clk) disable iff (!rst_n)
      accept && write && hitFirst && byteenable == 4'hF |=> firstReg == $past(writedata);
  endproperty
  a_write_first: assert property (p_write_first) else $error("first reg write lost");
  property p_write_second;
    @(posedge core_clk) disable iff (!rst_n)
      accept && write && hitSecond && byteenable == 4'hF |=> secondReg == $past(writedata);
  endproperty
  a_write_second: assert property (p_write_second) else $error("second reg write lost");
  property p_repeat;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> firstCfg.repeatCount == {1'b0, $past(firstReg[5:4])} + 3'h1;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat count wrong");
  property p_advance;
    @(posedge core_clk) disable iff (!rst_n)
      firstReg[7:6] == 2'h3 ##1 firstReg[7:6] == 2'h3 |-> advanceDegrees == 7'h5A;
  endproperty
  a_advance: assert property (p_advance) else $error("advance angle wrong");
  property p_threshold;
    @(posedge core_clk) disable iff (!rst_n)
      firstReg[13:9] == 5'h12 |=> reservedCode;
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold code not flagged");
  property p_handoff;
    @(posedge core_clk) disable iff (!rst_n)
      secondReg[17:13] > 5'h18 |=> reservedCode && secondCfg.handoffThreshold > 5'h18;
  endproperty
  a_handoff: assert property (p_handoff) else $error("handoff code not flagged");
  property p_auto;
    @(posedge core_clk) disable iff (!rst_n) 1'b1 |=> secondCfg.autoHandoff == $past(secondReg[18]);
  endproperty
  a_auto: assert property (p_auto) else $error("auto handoff not following");
  property p_bit31;
    @(posedge core_clk) disable iff (!rst_n)
      $changed(secondReg[31]) && $stable(secondReg[30:0]) |=> $stable(secondCfg);
  endproperty
  a_bit31: assert property (p_bit31) else $error("reserved bit changed settings");

  property p_threshold_field;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> firstCfg.detectThreshold == $past(firstReg[13:9]);
  endproperty
  a_threshold_field: assert property (p_threshold_field)
    else $error("threshold field not following");

  property p_release;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> firstCfg.releaseTristate == $past(firstReg[8]);
  endproperty
  a_release: assert property (p_release)
    else $error("release mode not following");

  property p_limit_source;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> firstCfg.limitFromGeneral == $past(firstReg[3]);
  endproperty
  a_limit_source: assert property (p_limit_source)
    else $error("limit source not following");

  property p_ramp;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> firstCfg.torqueRampEnable == $past(firstReg[2]);
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp enable not following");

  property p_brake;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> firstCfg.activeBrakeEnable == $past(firstReg[1]);
  endproperty
  a_brake: assert property (p_brake)
    else $error("brake enable not following");

  property p_reverse;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> firstCfg.reverseUsesOwn == $past(firstReg[0]);
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("reverse select not following");

  property p_method;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> firstCfg.startMethod == $past(firstReg[30:29]);
  endproperty
  a_method: assert property (p_method)
    else $error("start method not following");

  property p_ol_limit;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> secondCfg.openLoopLimit == $past(secondReg[30:27]);
  endproperty
  a_ol_limit: assert property (p_ol_limit)
    else $error("open-loop limit not following");

  property p_accel_first;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> secondCfg.accelFirstOrder == $past(secondReg[26:23]);
  endproperty
  a_accel_first: assert property (p_accel_first)
    else $error("first-order coefficient not following");

  property p_accel_second;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> secondCfg.accelSecondOrder == $past(secondReg[22:19]);
  endproperty
  a_accel_second: assert property (p_accel_second)
    else $error("second-order coefficient not following");

  property p_handoff_field;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> secondCfg.handoffThreshold == $past(secondReg[17:13]);
  endproperty
  a_handoff_field: assert property (p_handoff_field)
    else $error("handoff threshold not following");

  property p_gap;
    @(posedge core_clk) disable iff (!rst_n)
      secondReg[22:19] == 4'hA |=> reservedCode;
  endproperty
  a_gap: assert property (p_gap)
    else $error("coefficient gap not flagged");

  property p_flag_low;
    @(posedge core_clk) disable iff (!rst_n)
      !badCode |=> !reservedCode;
  endproperty
  a_flag_low: assert property (p_flag_low)
    else $error("flag raised without cause");

  property p_read_stands;
    @(posedge core_clk) disable iff (!rst_n)
      start && read && hitFirst |=> readdata == $past(firstReg);
  endproperty
  a_read_stands: assert property (p_read_stands)
    else $error("first reg read data not standing");

  property p_read_second;
    @(posedge core_clk) disable iff (!rst_n)
      start && read && hitSecond |=> readdata == $past(secondReg);
  endproperty
  a_read_second: assert property (p_read_second)
    else $error("second reg read data not standing");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      !(start && read) |=> $stable(readdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved without a read");

  property p_err_resp;
    @(posedge core_clk) disable iff (!rst_n)
      start && !hitFirst && !hitSecond && !hitStatus |=> response == 2'h2;
  endproperty
  a_err_resp: assert property (p_err_resp)
    else $error("unmapped access not refused");

  property p_ok_resp;
    @(posedge core_clk) disable iff (!rst_n)
      start && (hitFirst || hitSecond) |=> response == 2'h0;
  endproperty
  a_ok_resp: assert property (p_ok_resp)
    else $error("mapped access refused");

  property p_unmapped_write;
    @(posedge core_clk) disable iff (!rst_n)
      accept && write && !hitFirst && !hitSecond |=> $stable(firstReg) && $stable(secondReg);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("unmapped write changed storage");

  property p_write_lanes;
    @(posedge core_clk) disable iff (!rst_n)
      accept && write && hitFirst && byteenable == 4'h1 |=> firstReg[31:8] == $past(firstReg[31:8]);
  endproperty
  a_write_lanes: assert property (p_write_lanes)
    else $error("disabled lanes written");

  property p_reset_wait;
    @(posedge core_clk) !rst_n |=> waitrequest && readdata == 32'h00000000;
  endproperty
  a_reset_wait: assert property (p_reset_wait)
    else $error("bus outputs not idle after reset");

  property p_wait_single;
    @(posedge core_clk) disable iff (!rst_n)
      !waitrequest |=> waitrequest;
  endproperty
  a_wait_single: assert property (p_wait_single)
    else $error("waitrequest low too long");

  c_write_first: cover property (@(posedge core_clk) accept && write && hitFirst);
  c_status_read: cover property (@(posedge core_clk) accept && read && hitStatus);
  c_read_second: cover property (@(posedge core_clk) accept && read && hitSecond);
  c_unmapped: cover property (@(posedge core_clk) accept && !hitFirst && !hitSecond && !hitStatus);
  c_reserved: cover property (@(posedge core_clk) reservedCode);
endmodule : motor_startup_config_regs
`default_nettype wire

// >>> sim/tb_motor_startup_config_regs.sv
// self-checking bench for the motor start-up register bank
`timescale 1ns/1ps
`default_nettype none
module tb_motor_startup_config_regs;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  motor_startup_pkg::startup_first_type firstCfg;
  motor_startup_pkg::startup_second_type secondCfg;
  logic [6:0] advanceDegrees;
  logic reservedCode;
  logic [31:0] rdata;
  logic [1:0] resp;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  motor_startup_config_regs u_motor_startup_config_regs (.core_clk(core_clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .firstCfg(firstCfg), .secondCfg(secondCfg),
    .advanceDegrees(advanceDegrees), .reservedCode(reservedCode));
  always #2 core_clk = ~core_clk;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    n_compared++;
    if (seen !== expected) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check
  // holds the request until waitrequest is sampled low, then releases
  task automatic access(input logic isWrite, input logic [7:0] addr, input logic [31:0] data,
    input logic [3:0] lanes);
    @(posedge core_clk);
    address <= addr;
    writedata <= data;
    byteenable <= lanes;
    write <= isWrite;
    read <= !isWrite;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    rdata = readdata;
    resp = response;
    read <= 1'b0;
    write <= 1'b0;
    // decoded outputs lag the register by one cycle
    repeat (2) @(posedge core_clk);
  endtask : access
  task automatic writeFlag(input logic [7:0] addr, input logic [31:0] data, input logic flag);
    access(1'b1, addr, data, 4'hF);
    check({31'h0, reservedCode}, {31'h0, flag});
    access(1'b0, 8'h8C, 32'h0, 4'hF);
    check({31'h0, rdata[0]}, {31'h0, flag});
  endtask : writeFlag
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict;
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  task automatic testFields;
    access(1'b0, 8'h84, 32'h0, 4'hF);
    check(rdata, 32'h0);
    access(1'b0, 8'h86, 32'h0, 4'hF);
    check({rdata[31:30], resp}, 4'h0);
    check({14'h0, secondCfg}, 32'h0);
    access(1'b1, 8'h84, 32'h600023FF, 4'hF);
    access(1'b0, 8'h84, 32'h0, 4'hF);
    check(rdata, 32'h600023FF);
    check({15'h0, firstCfg}, {15'h0, 2'h3, 5'h11, 1'b1, 2'h3, 3'h4, 4'hF});
    check({31'h0, reservedCode}, 32'h0);
    $display("field test done");
  endtask : testFields
  task automatic testAngleRepeat;
    for (int i = 0; i < 4; i++) begin
      access(1'b1, 8'h84, {24'h0, i[1:0], i[1:0], 4'h0}, 4'hF);
      check({25'h0, advanceDegrees}, 32'(i * 30));
      check({29'h0, firstCfg.repeatCount}, 32'(i + 1));
    end
    $display("angle and repeat test done");
  endtask : testAngleRepeat
  task automatic testSecond;
    writeFlag(8'h86, 32'hFCD70000, 1'b1);
    check({14'h0, secondCfg}, {14'h0, 4'hF, 4'h9, 4'hA, 1'b1, 5'h18});
    writeFlag(8'h86, 32'hFCCF0000, 1'b0);
    writeFlag(8'h86, 32'hFCCF2000, 1'b1);
    writeFlag(8'h86, 32'hFCCF0000, 1'b0);
    writeFlag(8'h84, 32'h00002400, 1'b1);
    // only the top lane is cleared, so bit 31 must fall with it
    access(1'b1, 8'h86, 32'h0, 4'h8);
    access(1'b0, 8'h86, 32'h0, 4'hF);
    check(rdata, 32'h00CF0000);
    $display("second register test done");
  endtask : testSecond
  task automatic testUnmapped;
    access(1'b1, 8'h90, 32'hFFFFFFFF, 4'hF);
    check({30'h0, resp}, 32'h2);
    access(1'b0, 8'h90, 32'h0, 4'hF);
    check({resp, rdata[29:0]}, 32'h80000000);
    $display("unmapped test done");
  endtask : testUnmapped
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    testFields;
    testAngleRepeat;
    testSecond;
    testUnmapped;
    print_verdict;
  end
endmodule : tb_motor_startup_config_regs
`default_nettype wire
